// File: core/pcs_top.sv
/*
  Two-socket card status and strobe block: register file, speaker
  merge, DMA request and ring reporting, and byte-lane card enables.
  Assumes card pins are asynchronous; the register port and the
  access request come from logic on sys_clk.
*/
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pcs_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] battery_detect_one,
  input wire logic [1:0] battery_detect_two,
  input wire logic [1:0] card_detect_one,
  input wire logic [1:0] card_detect_two,
  input wire logic acc_valid,
  input wire logic acc_sock,
  input wire logic acc_odd,
  input wire logic acc_wide,
  output logic [1:0] even_byte_enable_n,
  output logic [1:0] odd_byte_enable_n,
  output logic merged_speaker_out,
  output logic [1:0] dma_request,
  output logic [1:0] ring_detected,
  output logic [1:0] status_change_pending
);

  // ****************************************
  // Socket front ends
  // ****************************************
  pcs_sock_if sif [pcs_pkg::SOCKETS] ();

  logic [1:0][3:0] pins_w;
  logic [1:0][3:0] evt_w;
  logic [1:0][1:0] batt_w;
  logic [1:0] ins_w;

  logic [1:0][7:0] ctrl_ff, nxt_ctrl;
  logic [1:0][7:0] en_ff, nxt_en;
  logic [1:0][7:0] chg_ff, nxt_chg;
  logic [1:0][7:0] clr;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [1:0] even_ff, nxt_even;
  logic [1:0] odd_ff, nxt_odd;
  logic [1:0] dma_ff, nxt_dma;
  logic [1:0] ring_ff, nxt_ring;
  logic [1:0] pend_ff, nxt_pend;
  logic spk_ff, nxt_spk;
  logic sel;
  logic hit;
  logic [1:0] spk_bit;
  logic [1:0] lane_hit;

  for (genvar s = 0; s < pcs_pkg::SOCKETS; s++) begin : g_sock
    pcs_socket u_sock (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bvd_one_pin(battery_detect_one[s]),
      .bvd_two_pin(battery_detect_two[s]),
      .cd_one_pin(card_detect_one[s]),
      .cd_two_pin(card_detect_two[s]),
      .sif(sif[s])
    );
    assign pins_w[s] = sif[s].pins;
    assign evt_w[s] = sif[s].evt;
    assign batt_w[s] = sif[s].batt;
    assign ins_w[s] = sif[s].inserted;
    assign sif[s].io_mode = ctrl_ff[s][pcs_pkg::CTRL_IO];
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    sel = reg_addr[pcs_pkg::ADDR_SOCK_BIT];
    hit = ~reg_addr[pcs_pkg::ADDR_HI_BIT];
    nxt_ctrl = ctrl_ff;
    nxt_en = en_ff;
    nxt_rdata = '0;
    clr = '0;
    if (reg_wr && hit) begin
      unique case (reg_addr[1:0])
        pcs_pkg::REG_IFSTAT: begin
        end
        pcs_pkg::REG_CHG: begin
          clr[sel] = reg_wdata & pcs_pkg::EVT_MASK;
        end
        pcs_pkg::REG_CHG_EN: begin
          nxt_en[sel] = reg_wdata & pcs_pkg::EVT_MASK;
        end
        pcs_pkg::REG_CTRL: begin
          nxt_ctrl[sel] = reg_wdata & pcs_pkg::CTRL_MASK;
        end
      endcase
    end
    // Set wins over a write-one-to-clear in the same cycle
    for (int s = 0; s < pcs_pkg::SOCKETS; s++) begin
      nxt_chg[s] = (chg_ff[s] & ~clr[s]) | {4'h0, evt_w[s]};
    end
    if (reg_rd && hit) begin
      unique case (reg_addr[1:0])
        pcs_pkg::REG_IFSTAT: begin
          nxt_rdata = {1'b0, batt_w[sel], ins_w[sel], pins_w[sel]};
        end
        pcs_pkg::REG_CHG: begin
          nxt_rdata = chg_ff[sel];
        end
        pcs_pkg::REG_CHG_EN: begin
          nxt_rdata = en_ff[sel];
        end
        pcs_pkg::REG_CTRL: begin
          nxt_rdata = ctrl_ff[sel];
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= {pcs_pkg::CTRL_RST, pcs_pkg::CTRL_RST};
      en_ff <= {pcs_pkg::CHG_EN_RST, pcs_pkg::CHG_EN_RST};
      chg_ff <= {pcs_pkg::CHG_RST, pcs_pkg::CHG_RST};
      rdata_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      en_ff <= nxt_en;
      chg_ff <= nxt_chg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Pin functions per socket
  // ****************************************
  always_comb begin
    for (int s = 0; s < pcs_pkg::SOCKETS; s++) begin
      // DMA takes the line away from the speaker use
      nxt_dma[s] = ctrl_ff[s][pcs_pkg::CTRL_DMA] &
                   pins_w[s][pcs_pkg::PIN_BVD_TWO];
      spk_bit[s] = ctrl_ff[s][pcs_pkg::CTRL_IO] &
                   ~ctrl_ff[s][pcs_pkg::CTRL_DMA] &
                   pins_w[s][pcs_pkg::PIN_BVD_TWO];
      nxt_ring[s] = ctrl_ff[s][pcs_pkg::CTRL_IO] &
                    ~pins_w[s][pcs_pkg::PIN_BVD_ONE];
      nxt_pend[s] = |(chg_ff[s] & en_ff[s]);
      // No strobe toward an empty socket
      lane_hit[s] = acc_valid & (acc_sock == s[0]) & ins_w[s];
      nxt_even[s] = ~(lane_hit[s] & (acc_wide | ~acc_odd));
      nxt_odd[s] = ~(lane_hit[s] & (acc_wide | acc_odd));
    end
    nxt_spk = spk_bit[0] ^ spk_bit[1];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_ff <= '0;
      ring_ff <= '0;
      pend_ff <= '0;
      even_ff <= '1;
      odd_ff <= '1;
      spk_ff <= 1'b0;
    end else begin
      dma_ff <= nxt_dma;
      ring_ff <= nxt_ring;
      pend_ff <= nxt_pend;
      even_ff <= nxt_even;
      odd_ff <= nxt_odd;
      spk_ff <= nxt_spk;
    end
  end

  assign reg_rdata = rdata_ff;
  assign even_byte_enable_n = even_ff;
  assign odd_byte_enable_n = odd_ff;
  assign merged_speaker_out = spk_ff;
  assign dma_request = dma_ff;
  assign ring_detected = ring_ff;
  assign status_change_pending = pend_ff;

endmodule

// File: core/pcs_pkg.sv
/*
  Shared constants for the two-socket card status and strobe block:
  register map, field positions, reset values and the battery type.
  Assumes one 10 MHz clock and a plain single-cycle register port.
*/
package pcs_pkg;

  localparam int SOCKETS = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_W = 4;
  localparam int EVT_W = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] REG_IFSTAT = 2'h0;
  localparam logic [1:0] REG_CHG = 2'h1;
  localparam logic [1:0] REG_CHG_EN = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  localparam int ADDR_SOCK_BIT = 2;
  localparam int ADDR_HI_BIT = 3;

  // Synchronised pin vector positions
  localparam int PIN_BVD_ONE = 0;
  localparam int PIN_BVD_TWO = 1;
  localparam int PIN_CD_ONE = 2;
  localparam int PIN_CD_TWO = 3;

  // Change event positions
  localparam int EVT_DEAD = 0;
  localparam int EVT_WEAK = 1;
  localparam int EVT_DETECT = 2;
  localparam int EVT_ALERT = 3;

  // Control fields
  localparam int CTRL_IO = 0;
  localparam int CTRL_DMA = 1;
  localparam logic [7:0] CTRL_MASK = 8'h03;
  localparam logic [7:0] EVT_MASK = 8'h0f;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CHG_EN_RST = 8'h00;
  localparam logic [7:0] CHG_RST = 8'h00;
  localparam logic [3:0] PIN_RST = 4'hf;

  typedef enum logic [1:0] {
    PCS_BATT_GOOD = 2'h0,
    PCS_BATT_WEAK = 2'h1,
    PCS_BATT_DEAD = 2'h3
  } pcs_batt_t;

endpackage

// File: core/pcs_sock_if.sv
/*
  Carrier between one socket front end and the register core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pcs_sock_if;
  logic [3:0] pins;
  logic inserted;
  pcs_pkg::pcs_batt_t batt;
  logic [3:0] evt;
  logic io_mode;

  modport sock (
    output pins,
    output inserted,
    output batt,
    output evt,
    input io_mode
  );

  modport core (
    input pins,
    input inserted,
    input batt,
    input evt,
    output io_mode
  );
endinterface

// File: core/pcs_socket.sv
/*
  One socket front end: synchronises the four status pins, decodes
  battery and insertion state and raises one-cycle change events.
  Assumes pins are asynchronous to sys_clk and io_mode is registered.
*/
`timescale 1ns/1ps
module pcs_socket (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bvd_one_pin,
  input wire logic bvd_two_pin,
  input wire logic cd_one_pin,
  input wire logic cd_two_pin,
  pcs_sock_if.sock sif
);

  logic [3:0] meta_ff, nxt_meta;
  logic [3:0] sync_ff, nxt_sync;
  logic [3:0] prev_ff, nxt_prev;
  logic ins_now, ins_prev;

  // ****************************************
  // Synchroniser and history
  // ****************************************
  always_comb begin
    nxt_meta = {cd_two_pin, cd_one_pin, bvd_two_pin, bvd_one_pin};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= pcs_pkg::PIN_RST;
      sync_ff <= pcs_pkg::PIN_RST;
      prev_ff <= pcs_pkg::PIN_RST;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // ****************************************
  // Decode and change events
  // ****************************************
  always_comb begin
    // Detect pins are grounded inside the card
    ins_now = ~sync_ff[pcs_pkg::PIN_CD_ONE] &
              ~sync_ff[pcs_pkg::PIN_CD_TWO];
    ins_prev = ~prev_ff[pcs_pkg::PIN_CD_ONE] &
               ~prev_ff[pcs_pkg::PIN_CD_TWO];
    sif.inserted = ins_now;
    sif.pins = sync_ff;
    if (!sync_ff[pcs_pkg::PIN_BVD_ONE]) begin
      sif.batt = pcs_pkg::PCS_BATT_DEAD;
    end else if (!sync_ff[pcs_pkg::PIN_BVD_TWO]) begin
      sif.batt = pcs_pkg::PCS_BATT_WEAK;
    end else begin
      sif.batt = pcs_pkg::PCS_BATT_GOOD;
    end
    sif.evt = '0;
    sif.evt[pcs_pkg::EVT_DEAD] = ~sif.io_mode &
      prev_ff[pcs_pkg::PIN_BVD_ONE] & ~sync_ff[pcs_pkg::PIN_BVD_ONE];
    sif.evt[pcs_pkg::EVT_WEAK] = ~sif.io_mode &
      sync_ff[pcs_pkg::PIN_BVD_ONE] &
      prev_ff[pcs_pkg::PIN_BVD_TWO] & ~sync_ff[pcs_pkg::PIN_BVD_TWO];
    sif.evt[pcs_pkg::EVT_DETECT] = ins_now ^ ins_prev;
    // Status-change line is active low from the card
    sif.evt[pcs_pkg::EVT_ALERT] = sif.io_mode &
      prev_ff[pcs_pkg::PIN_BVD_ONE] & ~sync_ff[pcs_pkg::PIN_BVD_ONE];
  end

endmodule

// File: tb/pcs_top_monitor.sv
/* Port assertions for the card status block.
   Bound to pcs_top; one clock, async active-low reset. */
`timescale 1ns/1ps
module pcs_top_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] battery_detect_one,
  input wire logic [1:0] battery_detect_two,
  input wire logic [1:0] card_detect_one,
  input wire logic [1:0] card_detect_two,
  input wire logic acc_valid,
  input wire logic acc_sock,
  input wire logic acc_odd,
  input wire logic acc_wide,
  input wire logic [1:0] even_byte_enable_n,
  input wire logic [1:0] odd_byte_enable_n,
  input wire logic [1:0] dma_request,
  input wire logic [1:0] ring_detected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Five samples outlast the synchroniser and decode
  sequence s_in0;
    (!card_detect_one[0] && !card_detect_two[0])[*5];
  endsequence
  sequence s_in1;
    (!card_detect_one[1] && !card_detect_two[1])[*5];
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_even;
    s_in0 ##0 (acc_valid && !acc_sock && !acc_odd && !acc_wide)
    |=> !even_byte_enable_n[0] && odd_byte_enable_n[0];
  endproperty
  property p_odd;
    s_in1 ##0 (acc_valid && acc_sock && acc_odd && !acc_wide)
    |=> even_byte_enable_n[1] && !odd_byte_enable_n[1];
  endproperty
  property p_wide;
    s_in0 ##0 (acc_valid && !acc_sock && acc_wide)
    |=> !even_byte_enable_n[0] && !odd_byte_enable_n[0];
  endproperty
  property p_idle;
    !acc_valid |=> even_byte_enable_n == 2'h3 && odd_byte_enable_n == 2'h3;
  endproperty
  property p_nocard;
    card_detect_one[0] [*5] |-> even_byte_enable_n[0] && odd_byte_enable_n[0];
  endproperty
  property p_dma;
    (!battery_detect_two[0]) [*4] |-> !dma_request[0];
  endproperty
  property p_ring;
    battery_detect_one[0] [*4] |-> !ring_detected[0];
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside slot");
  a_even: assert property (p_even)
    else $error("even lane wrong");
  a_odd: assert property (p_odd)
    else $error("odd lane wrong");
  a_wide: assert property (p_wide)
    else $error("wide lanes wrong");
  a_idle: assert property (p_idle)
    else $error("lane on without request");
  a_nocard: assert property (p_nocard)
    else $error("lane on for empty socket");
  a_dma: assert property (p_dma)
    else $error("dma without request");
  a_ring: assert property (p_ring)
    else $error("ring with line high");
  c_even: cover property (!even_byte_enable_n[0]);
  c_dma: cover property (dma_request[0]);
  c_ring: cover property (ring_detected[0]);
endmodule

bind pcs_top pcs_top_monitor u_mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .battery_detect_one(battery_detect_one),
  .battery_detect_two(battery_detect_two),
  .card_detect_one(card_detect_one), .card_detect_two(card_detect_two),
  .acc_valid(acc_valid), .acc_sock(acc_sock), .acc_odd(acc_odd),
  .acc_wide(acc_wide), .even_byte_enable_n(even_byte_enable_n),
  .odd_byte_enable_n(odd_byte_enable_n), .dma_request(dma_request),
  .ring_detected(ring_detected)
);

// File: tb/pcs_card_model.sv
/* Two card slots as seen from the socket pins.
   Assumes pull-ups on every status pin of an empty slot. */
`timescale 1ns/1ps
module pcs_card_model (
  input wire logic [1:0] present,
  input wire logic [1:0] bat_one,
  input wire logic [1:0] bat_two,
  output logic [1:0] battery_detect_one,
  output logic [1:0] battery_detect_two,
  output logic [1:0] card_detect_one,
  output logic [1:0] card_detect_two,
  input wire logic [1:0] busy,
  output logic [1:0] card_ready
);
  // Card grounds both detect pins
  assign card_detect_one = ~present;
  assign card_detect_two = ~present;
  // Empty slot floats to the pull-up
  assign battery_detect_one = bat_one | ~present;
  assign battery_detect_two = bat_two | ~present;
  // A busy card holds ready low; an empty slot reads the pull-up
  assign card_ready = ~busy | ~present;
endmodule

// File: tb/pcs_top_tb_top.sv
/* Self-checking bench for the card status block.
   Assumes the card model above and the bound port monitor. */
`timescale 1ns/1ps
module pcs_top_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, av = 0, as = 0, ao = 0, aw = 0;
  logic spk;
  logic [3:0] ad = 4'h0;
  logic [7:0] wd = 8'h00, rdat;
  logic [1:0] pres = 2'h0, b1 = 2'h3, b2 = 2'h3, bd1, bd2, cd1, cd2;
  logic [1:0] ev_n, od_n, dma, ring, pend;
  logic [1:0] bsy = 2'h0, rdy;
  int bad_count = 0, compares = 0;
  initial forever #50 clk = ~clk;
  pcs_card_model card (.present(pres), .bat_one(b1), .bat_two(b2),
    .battery_detect_one(bd1), .battery_detect_two(bd2),
    .card_detect_one(cd1), .card_detect_two(cd2), .busy(bsy),
    .card_ready(rdy));
  pcs_top dut (.sys_clk(clk), .reset_n(rst_n), .reg_addr(ad),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .battery_detect_one(bd1), .battery_detect_two(bd2),
    .card_detect_one(cd1), .card_detect_two(cd2), .acc_valid(av),
    .acc_sock(as), .acc_odd(ao), .acc_wide(aw),
    .even_byte_enable_n(ev_n), .odd_byte_enable_n(od_n),
    .merged_speaker_out(spk), .dma_request(dma),
    .ring_detected(ring), .status_change_pending(pend));
  // ****************************************
  // Bus tasks
  // ****************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {wr, ad, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {rd, ad} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(rdat, e);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task complete_run;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    complete_run;
  end
  initial begin
    logic [1:0] v, s;
    idle(2);
    rst_n <= 1;
    rd_reg(4'h0, 8'h0f);
    wr_reg(4'h6, 8'h04);
    @(posedge clk) pres <= 2'h3;
    idle(6);
    chk({6'h00, pend}, 8'h02);
    bsy <= 2'h1;
    #1 chk({6'h00, rdy}, 8'h02);
    wr_reg(4'h4, 8'hff);
    rd_reg(4'h4, 8'h13);
    rd_reg(4'h6, 8'h04);
    rd_reg(4'h1, 8'h04);
    wr_reg(4'h1, 8'h04);
    rd_reg(4'h1, 8'h00);
    for (int i = 3; i >= 0; i--) begin
      v = i[1:0];
      @(posedge clk) {b1[0], b2[0]} <= v;
      idle(5);
      rd_reg(4'h0, {1'b0, v[1] ? {1'b0, !v[0]} : 2'h3, 3'h4, v[0], v[1]});
    end
    rd_reg(4'h1, 8'h03);
    wr_reg(4'h1, 8'h0f);
    wr_reg(4'h3, 8'h01);
    @(posedge clk) {b1, b2} <= 4'hf;
    idle(5);
    chk({7'h00, spk}, 8'h01);
    @(posedge clk) b1[0] <= 0;
    idle(5);
    chk({6'h00, ring}, 8'h01);
    rd_reg(4'h1, 8'h08);
    wr_reg(4'h7, 8'h01);
    idle(5);
    chk({7'h00, spk}, 8'h00);
    wr_reg(4'h3, 8'h03);
    idle(5);
    chk({5'h00, spk, dma}, 8'h05);
    @(posedge clk) b2[0] <= 0;
    idle(5);
    chk({6'h00, dma}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) {av, as, ao, aw} <= {1'b1, i[0], i[2:1] == 1, i[2]};
      @(posedge clk) s = as ? 2'h1 : 2'h2;
      #1 chk({4'h0, ev_n, od_n}, {4'h0, aw | !ao ? s : 2'h3,
        aw | ao ? s : 2'h3});
    end
    @(posedge clk) {pres, as} <= 3'h4;
    idle(6);
    chk({6'h00, ev_n & od_n}, 8'h03);
    wr_reg(4'hb, 8'hff);
    rd_reg(4'hb, 8'h00);
    rd_reg(4'h3, 8'h03);
    chk({7'h00, spk}, 8'h01);
    @(posedge clk) rst_n <= 0;
    idle(2);
    rst_n <= 1;
    rd_reg(4'h7, 8'h00);
    chk({7'h00, spk}, 8'h00);
    complete_run;
  end
endmodule
